/* common/npc_defines.vh */
// Constants and field layout for the memory port control block.
// Overview of operation
// - Combined mode makes the port-zero pin a one-bit port at control bit 0.
// - Combined mode: port-zero is input when bit 4 clear, output when set.
// - Separate mode drives port-zero as an SRAM address output except in test mode.
// - Test mode entered if test-select high and strap low at reset release.
// - Test mode floats the port pins, port-zero and the data bus; memory selects and address stay driven.
// - Port pins are strobes and write enable, or SRAM address lines.
// - Combined mode maps 08XXh accesses to the stored 13-bit index.
// - Combined mode ignores the low address byte within 08XXh.
// - High index bit 4 drives memory address line 12.
// - Separate mode maps 0800h-08FFh onto the 256 bytes of the window.
// - Separate mode drives control bits 3..0 as SRAM address 11..8.
// - Sixteen windows of 256 bytes reachable without rewriting bytes.
// - Control bit 6 selects combined (0) or separate (1) mode.
// - Control bit 7 drives id_read_en_o, default off; reads of 0C01h return the ID regardless of it.
// - Combined mode: high index write strobes five bits onto the external data bus.
// - Combined mode: low index write strobes eight bits onto the external data bus.
`ifndef NPC_DEFINES_VH
`define NPC_DEFINES_VH
`define NPC_ADDR_CTRL 16'h0C00
`define NPC_ADDR_IDXH 16'h0C01
`define NPC_ADDR_IDXL 16'h0C08
`define NPC_WIN_PAGE 8'h08
`define NPC_BIT_PORT 0
`define NPC_BIT_DIR 4
`define NPC_BIT_MODE 6
`define NPC_BIT_IDEN 7
`define NPC_CTRL_RST 8'h00
`define NPC_CTRL_WMASK 8'hDF
`define NPC_REV_ID 8'h01
`define NPC_STRAP_WAIT 3'h4
`endif

/* design/npc_sync3.v */
// Three-stage input synchroniser with agreement filter.
`timescale 1ns/10ps
module npc_sync3 (
   input wire mclk_i,
   input wire arst_n_i,
   input wire d_i,
   output reg q_o
);
   reg s1_ff;
   reg s2_ff;
   reg s3_ff;
   always @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         s1_ff <= 1'b1;
         s2_ff <= 1'b1;
         s3_ff <= 1'b1;
         q_o <= 1'b1;
      end else begin
         s1_ff <= d_i;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         // Only a level that held for two samples is accepted.
         if (s2_ff == s3_ff) begin
            q_o <= s3_ff;
         end
      end
   end
endmodule

/* design/npc_strap.v */
// Test-mode strap capture at reset release.
`timescale 1ns/10ps
`include "npc_defines.vh"
module npc_strap (
   input wire mclk_i,
   input wire arst_n_i,
   input wire tsel_i,
   input wire tmod_n_i,
   output reg test_mode_o
);
   reg done_ff;
   reg [2:0] wait_ff;
   always @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         done_ff <= 1'b0;
         wait_ff <= 3'h0;
         test_mode_o <= 1'b0;
      end else if (!done_ff) begin
         // The synchronisers restart with reset, so the straps are taken
         // only once their outputs carry the pin levels again.
         if (wait_ff == `NPC_STRAP_WAIT) begin
            done_ff <= 1'b1;
            test_mode_o <= tsel_i & ~tmod_n_i;
         end else begin
            wait_ff <= wait_ff + 3'h1;
         end
      end
   end
endmodule

/* design/npc_port_ctrl.v */
// Nonvolatile memory access and port pin control.
`timescale 1ns/10ps
`include "npc_defines.vh"
module npc_port_ctrl (
   input wire mclk_i,
   input wire arst_n_i,
   input wire [15:0] io_addr_i,
   input wire io_rd_i,
   input wire io_wr_i,
   input wire [7:0] io_wdata_i,
   output reg [7:0] io_rdata_o,
   output reg io_rvalid_o,
   input wire [7:0] ext_data_i,
   output reg [7:0] ext_data_o,
   output reg ext_data_oe_o,
   input wire port_zero_test_select_i,
   output reg port_zero_test_select_o,
   output reg port_zero_test_select_oe_o,
   output reg rtc_strobe_one_port_one_o,
   output reg rtc_strobe_zero_port_two_o,
   output reg nvm_write_enable_port_three_o,
   output reg pins_oe_o,
   output reg [7:0] nvm_addr_low_o,
   output reg nvm_addr_a12_o,
   output reg nvm_cs_n_o,
   output reg nvm_oe_n_o,
   input wire keyboard_select_test_strap_i,
   output reg id_read_en_o,
   output reg test_mode_o
);
   localparam ST_IDLE = 3'b001;
   localparam ST_ACC = 3'b010;
   localparam ST_END = 3'b100;

   reg [7:0] ctrl_ff;
   reg [4:0] idx_hi_ff;
   reg [7:0] idx_lo_ff;
   reg [2:0] st_ff;
   reg [2:0] nxt_st;
   reg acc_wr_ff;
   reg data_hold_ff;
   reg [2:0] strb_ff;
   wire pin_sync;
   wire tsel_sync;
   wire tmod_sync;
   wire test_mode;
   wire sep_mode;
   wire dir_out;
   wire win_hit;

   function is_addr;
      input [15:0] a;
      input [15:0] ref_a;
      begin
         is_addr = (a == ref_a);
      end
   endfunction

   npc_sync3 u_sync_pin (
      .mclk_i(mclk_i),
      .arst_n_i(arst_n_i),
      .d_i(port_zero_test_select_i),
      .q_o(pin_sync)
   );
   npc_sync3 u_sync_strap (
      .mclk_i(mclk_i),
      .arst_n_i(arst_n_i),
      .d_i(keyboard_select_test_strap_i),
      .q_o(tmod_sync)
   );
   assign tsel_sync = pin_sync;

   npc_strap u_strap (
      .mclk_i(mclk_i),
      .arst_n_i(arst_n_i),
      .tsel_i(tsel_sync),
      .tmod_n_i(tmod_sync),
      .test_mode_o(test_mode)
   );

   assign sep_mode = ctrl_ff[`NPC_BIT_MODE];
   assign dir_out = ctrl_ff[`NPC_BIT_DIR];
   // Any low byte hits: the page alone is the chip select.
   assign win_hit = (io_addr_i[15:8] == `NPC_WIN_PAGE);

   // Register writes; bit 5 has no storage effect.
   always @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ctrl_ff <= `NPC_CTRL_RST;
         idx_hi_ff <= 5'h00;
         idx_lo_ff <= 8'h00;
      end else if (io_wr_i && st_ff == ST_IDLE) begin
         if (is_addr(io_addr_i, `NPC_ADDR_CTRL)) begin
            ctrl_ff <= io_wdata_i & `NPC_CTRL_WMASK;
         end
         if (is_addr(io_addr_i, `NPC_ADDR_IDXH)) begin
            idx_hi_ff <= io_wdata_i[4:0];
         end
         if (is_addr(io_addr_i, `NPC_ADDR_IDXL)) begin
            idx_lo_ff <= io_wdata_i;
         end
      end
   end

   // Access sequencer: one strobe cycle, then a recovery cycle.
   always @* begin
      case (st_ff)
         ST_IDLE: begin
            if ((io_rd_i || io_wr_i) && win_hit) begin
               nxt_st = ST_ACC;
            end else begin
               nxt_st = ST_IDLE;
            end
         end
         ST_ACC: nxt_st = ST_END;
         ST_END: nxt_st = ST_IDLE;
         default: nxt_st = ST_IDLE;
      endcase
   end

   always @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         st_ff <= ST_IDLE;
         acc_wr_ff <= 1'b0;
         data_hold_ff <= 1'b0;
         strb_ff <= 3'b111;
         nvm_cs_n_o <= 1'b1;
         nvm_oe_n_o <= 1'b1;
         ext_data_o <= 8'h00;
         ext_data_oe_o <= 1'b0;
         io_rdata_o <= 8'h00;
         io_rvalid_o <= 1'b0;
         nvm_addr_low_o <= 8'h00;
         nvm_addr_a12_o <= 1'b0;
      end else begin
         st_ff <= nxt_st;
         io_rvalid_o <= 1'b0;
         strb_ff <= 3'b111;
         // Data stays driven through the strobe cycle that latches it.
         ext_data_oe_o <= data_hold_ff;
         data_hold_ff <= 1'b0;
         nvm_cs_n_o <= 1'b1;
         nvm_oe_n_o <= 1'b1;
         nvm_addr_a12_o <= idx_hi_ff[4];
         if (st_ff == ST_IDLE && io_wr_i && !sep_mode) begin
            // Index writes are passed to the clock chip at once.
            if (is_addr(io_addr_i, `NPC_ADDR_IDXH)) begin
               ext_data_o <= {3'b000, io_wdata_i[4:0]};
               ext_data_oe_o <= 1'b1;
               data_hold_ff <= 1'b1;
               strb_ff[0] <= 1'b0;
            end
            if (is_addr(io_addr_i, `NPC_ADDR_IDXL)) begin
               ext_data_o <= io_wdata_i;
               ext_data_oe_o <= 1'b1;
               data_hold_ff <= 1'b1;
               strb_ff[1] <= 1'b0;
            end
         end
         if (nxt_st == ST_ACC) begin
            acc_wr_ff <= io_wr_i;
            nvm_addr_low_o <= io_addr_i[7:0];
            nvm_cs_n_o <= 1'b0;
            nvm_oe_n_o <= io_wr_i;
            ext_data_o <= io_wdata_i;
            ext_data_oe_o <= io_wr_i;
            data_hold_ff <= io_wr_i;
            strb_ff[2] <= ~io_wr_i;
         end
         if (st_ff == ST_ACC && !acc_wr_ff) begin
            io_rdata_o <= ext_data_i;
            io_rvalid_o <= 1'b1;
         end
         if (st_ff == ST_IDLE && io_rd_i && !win_hit) begin
            io_rvalid_o <= 1'b1;
            if (is_addr(io_addr_i, `NPC_ADDR_CTRL)) begin
               // Input direction reports the pin, else the stored bit.
               io_rdata_o <= {ctrl_ff[7:1], (sep_mode || dir_out) ?
                  ctrl_ff[`NPC_BIT_PORT] : pin_sync};
            end else if (is_addr(io_addr_i, `NPC_ADDR_IDXH)) begin
               io_rdata_o <= `NPC_REV_ID;
            end else begin
               io_rdata_o <= 8'h00;
            end
         end
         if (test_mode) begin
            ext_data_oe_o <= 1'b0;
         end
      end
   end

   // Pin muxing; registered so each output is a flip-flop.
   always @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         port_zero_test_select_o <= 1'b0;
         port_zero_test_select_oe_o <= 1'b0;
         rtc_strobe_one_port_one_o <= 1'b1;
         rtc_strobe_zero_port_two_o <= 1'b1;
         nvm_write_enable_port_three_o <= 1'b1;
         pins_oe_o <= 1'b0;
         id_read_en_o <= 1'b0;
         test_mode_o <= 1'b0;
      end else begin
         test_mode_o <= test_mode;
         id_read_en_o <= ctrl_ff[`NPC_BIT_IDEN];
         pins_oe_o <= ~test_mode;
         port_zero_test_select_o <= ctrl_ff[`NPC_BIT_PORT];
         port_zero_test_select_oe_o <= ~test_mode &
            (sep_mode | dir_out);
         if (sep_mode) begin
            rtc_strobe_one_port_one_o <= ctrl_ff[1];
            rtc_strobe_zero_port_two_o <= ctrl_ff[2];
            nvm_write_enable_port_three_o <= ctrl_ff[3];
         end else begin
            rtc_strobe_one_port_one_o <= strb_ff[0];
            rtc_strobe_zero_port_two_o <= strb_ff[1];
            nvm_write_enable_port_three_o <= strb_ff[2];
         end
      end
   end
endmodule

/* bench/npc_port_chk.sv */
// Assertion checker bound to the memory port control block.
`timescale 1ns/10ps
module npc_port_chk (
   input wire mclk_i,
   input wire arst_n_i,
   input wire [15:0] io_addr_i,
   input wire io_rd_i,
   input wire io_wr_i,
   input wire [7:0] io_wdata_i,
   input wire [7:0] io_rdata_o,
   input wire io_rvalid_o,
   input wire [7:0] ext_data_i,
   input wire [7:0] ext_data_o,
   input wire ext_data_oe_o,
   input wire port_zero_test_select_o,
   input wire port_zero_test_select_oe_o,
   input wire rtc_strobe_one_port_one_o,
   input wire rtc_strobe_zero_port_two_o,
   input wire nvm_write_enable_port_three_o,
   input wire pins_oe_o,
   input wire [7:0] nvm_addr_low_o,
   input wire nvm_cs_n_o,
   input wire nvm_oe_n_o,
   input wire id_read_en_o,
   input wire test_mode_o
);
   // Shadow of the last control write, so mode is known without peeking.
   reg [7:0] wd_ff;
   wire wr_c = io_wr_i && io_addr_i == 16'h0C00 && !test_mode_o;
   wire win = io_addr_i[15:8] == 8'h08;
   wire oe = port_zero_test_select_oe_o;
   wire [3:0] pins = {nvm_write_enable_port_three_o,
      rtc_strobe_zero_port_two_o, rtc_strobe_one_port_one_o,
      port_zero_test_select_o};
   always @(posedge mclk_i or negedge arst_n_i)
      if (!arst_n_i)
         wd_ff <= 8'h00;
      else if (wr_c)
         wd_ff <= io_wdata_i;
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!arst_n_i);
   sequence acc_s;
      !nvm_cs_n_o && !nvm_oe_n_o ##1 io_rvalid_o;
   endsequence
   sequence stb_s(s);
      ext_data_oe_o ##1 !s;
   endsequence
   comb_dir_a: assert property (
      wr_c && !io_wdata_i[6] |-> ##2 pins[3:1] == 3'h7 && oe == wd_ff[4]
      && (!wd_ff[4] || pins[0] == wd_ff[0])) else $error("port dir");
   sep_pin_a: assert property (
      wr_c && io_wdata_i[6] |-> ##2 pins == wd_ff[3:0] && oe)
      else $error("window pins");
   idx_lo_a: assert property (
      io_wr_i && io_addr_i == 16'h0C08 && !wd_ff[6] |=> ext_data_o ==
      $past(io_wdata_i) ##0 stb_s(rtc_strobe_zero_port_two_o))
      else $error("low index");
   idx_hi_a: assert property (
      io_wr_i && io_addr_i == 16'h0C01 && !wd_ff[6] |=> !((ext_data_o ^
      $past(io_wdata_i)) & 8'h1F) ##0 stb_s(rtc_strobe_one_port_one_o))
      else $error("high index");
   win_rd_a: assert property (
      io_rd_i && win |=> acc_s ##0 io_rdata_o == $past(ext_data_i))
      else $error("window read");
   sep_adr_a: assert property (
      io_rd_i && win && wd_ff[6] |=> {8'h08, nvm_addr_low_o} ==
      $past(io_addr_i)) else $error("window byte");
   reg_rd_a: assert property (
      io_rd_i && io_addr_i == 16'h0C00 |=> io_rvalid_o && !io_rdata_o[5]
      && io_rdata_o[7] == id_read_en_o) else $error("control read");
   test_tri_a: assert property (
      test_mode_o |-> !pins_oe_o && !ext_data_oe_o && !oe)
      else $error("test float");
endmodule
bind npc_port_ctrl npc_port_chk npc_port_chk_i (.*);

/* bench/npc_nvm_model.sv */
// Behavioural combined clock and memory chip on the external data bus.
`timescale 1ns/10ps
module npc_nvm_model (
   input wire mclk_i,
   input wire [7:0] bus_i,
   input wire bus_oe_i,
   input wire stb_hi_n_i,
   input wire stb_lo_n_i,
   input wire we_n_i,
   input wire oe_n_i,
   output wire [7:0] bus_o
);
   reg [7:0] mem_ff [0:8191];
   reg [12:0] idx_ff = 13'h0000;
   reg [7:0] held_ff = 8'h00;
   wire [7:0] v = bus_oe_i ? bus_i : ~held_ff;
   // Released, the bus keeps showing the last byte that was driven onto it.
   assign bus_o = oe_n_i ? ~v : mem_ff[idx_ff];
   always @(posedge mclk_i) begin
      if (bus_oe_i)
         held_ff <= bus_i;
      if (!stb_hi_n_i)
         idx_ff[12:8] <= v[4:0];
      if (!stb_lo_n_i)
         idx_ff[7:0] <= v;
      if (!we_n_i)
         mem_ff[idx_ff] <= v;
   end
endmodule

/* bench/npc_port_ctrl_tb.sv */
// Self-checking bench for the memory port control block.
`timescale 1ns/10ps
module npc_port_ctrl_tb;
   reg mclk_i = 1'b0, arst_n_i = 1'b0, io_rd_i = 1'b0, io_wr_i = 1'b0;
   reg [15:0] io_addr_i = 16'h0000;
   reg [7:0] io_wdata_i = 8'h00, d;
   reg pz = 1'b0, keyboard_select_test_strap_i = 1'b1;
   wire [7:0] io_rdata_o, ext_data_i, ext_data_o, nvm_addr_low_o;
   wire io_rvalid_o, ext_data_oe_o, port_zero_test_select_o, pins_oe_o;
   wire port_zero_test_select_oe_o, rtc_strobe_one_port_one_o, test_mode_o;
   wire rtc_strobe_zero_port_two_o, nvm_write_enable_port_three_o;
   wire nvm_addr_a12_o, nvm_cs_n_o, nvm_oe_n_o, id_read_en_o;
   wire port_zero_test_select_i = port_zero_test_select_oe_o ?
      port_zero_test_select_o : pz;
   integer fails = 0, compares = 0;
   always #4 mclk_i = ~mclk_i;
   npc_port_ctrl npc_port_ctrl_i (.*);
   npc_nvm_model npc_nvm_model_i (.mclk_i(mclk_i), .bus_i(ext_data_o),
      .bus_oe_i(ext_data_oe_o), .stb_hi_n_i(rtc_strobe_one_port_one_o),
      .stb_lo_n_i(rtc_strobe_zero_port_two_o),
      .we_n_i(nvm_write_enable_port_three_o), .oe_n_i(nvm_oe_n_o),
      .bus_o(ext_data_i));
   task chk(input [7:0] s, input [7:0] e);
      begin
         compares = compares + 1;
         if (s !== e) begin
            fails = fails + 1;
            $display("CHECK FAILED %0t seen %h want %h", $time, s, e);
         end
      end
   endtask
   // Five cycles per access covers the read latency and the busy spacing.
   task acc(input [15:0] a, input w, input [7:0] v);
      integer i;
      begin
         d = 8'hEE;
         @(posedge mclk_i);
         io_addr_i <= a;
         io_wr_i <= w;
         io_rd_i <= !w;
         io_wdata_i <= v;
         for (i = 0; i < 5; i = i + 1) begin
            @(posedge mclk_i);
            io_wr_i <= 1'b0;
            io_rd_i <= 1'b0;
            #1;
            if (io_rvalid_o === 1'b1)
               d = io_rdata_o;
         end
      end
   endtask
   task rst(input t);
      begin
         @(posedge mclk_i);
         arst_n_i <= 1'b0;
         pz <= t;
         keyboard_select_test_strap_i <= !t;
         repeat (5) @(posedge mclk_i);
         arst_n_i <= 1'b1;
         repeat (6) @(posedge mclk_i);
         pz <= 1'b0;
         keyboard_select_test_strap_i <= 1'b1;
         #1;
         chk({7'h00, test_mode_o}, {7'h00, t});
         chk({7'h00, pins_oe_o}, {7'h00, !t});
      end
   endtask
   task t_nvm;
      begin
         acc(16'h0C00, 1'b0, 8'h00);
         chk(d, 8'h00);
         acc(16'h0C01, 1'b1, 8'h13);
         chk({7'h00, nvm_addr_a12_o}, 8'h01);
         acc(16'h0C08, 1'b1, 8'h5C);
         acc(16'h0812, 1'b1, 8'hA7);
         acc(16'h0C01, 1'b1, 8'h03);
         acc(16'h08C4, 1'b1, 8'h3C);
         acc(16'h0800, 1'b0, 8'h00);
         chk(d, 8'h3C);
         acc(16'h0C01, 1'b1, 8'h13);
         acc(16'h08FF, 1'b0, 8'h00);
         chk(d, 8'hA7);
      end
   endtask
   task t_port;
      begin
         acc(16'h0C00, 1'b1, 8'hB1);
         acc(16'h0C00, 1'b0, 8'h00);
         chk(d, 8'h91);
         chk({7'h00, port_zero_test_select_i}, 8'h01);
         acc(16'h0C00, 1'b1, 8'h80);
         @(posedge mclk_i);
         pz <= 1'b1;
         repeat (6) @(posedge mclk_i);
         acc(16'h0C00, 1'b0, 8'h00);
         chk(d, 8'h81);
      end
   endtask
   task t_sep;
      begin
         acc(16'h0C00, 1'b1, 8'h4A);
         chk({4'h0, nvm_write_enable_port_three_o, rtc_strobe_zero_port_two_o,
            rtc_strobe_one_port_one_o, port_zero_test_select_o}, 8'h0A);
         acc(16'h08FF, 1'b0, 8'h00);
         chk(nvm_addr_low_o, 8'hFF);
      end
   endtask
   task final_report;
      begin
         if (fails == 0 && compares > 0)
            $display("All tests passed");
         else
            $display("Some tests failed");
         $finish;
      end
   endtask
   initial begin
      #50000;
      fails = fails + 1;
      final_report;
   end
   initial begin
      rst(1'b1);
      rst(1'b0);
      t_nvm;
      t_port;
      t_sep;
      final_report;
   end
endmodule
